/* File: hdl/bdsp_pkg.sv */
// package: constants for the background debug serial port
package bdsp_pkg;
  localparam int          WORD_BITS      = 17;
  localparam int          DATA_BITS      = 16;
  localparam int          STAT_POS       = 16;
  localparam logic [7:0]  VEC_BREAKPOINT = 8'h0c;
  localparam logic [7:0]  VEC_ILLEGAL    = 8'h04;
  localparam logic [7:0]  VEC_ADDR_ERR   = 8'h03;
  localparam logic [15:0] OP_ENTRY_INSN  = 16'h4afa;
  localparam logic [15:0] CAUSE_DBF_LO   = 16'hffff;
  localparam logic [15:0] CAUSE_INSN_LO  = 16'h0001;
  localparam logic [15:0] CAUSE_HW_LO    = 16'h0000;
  localparam logic [15:0] CAUSE_ZERO_HI  = 16'h0000;
  localparam logic [31:0] PCC_RESET_DBF  = 32'h00000001;
  localparam logic [15:0] RSP_COMPLETE   = 16'hffff;
  localparam logic [15:0] RSP_NOT_READY  = 16'h0000;
  localparam logic [15:0] RSP_BUS_ERR    = 16'h0001;
  localparam logic [15:0] RSP_ILLEGAL    = 16'hffff;
  localparam int          STRAP_CLKS     = 2;
  typedef enum logic [1:0] {
    BDSP_RUN,
    BDSP_HALT,
    BDSP_FROZEN
  } bdsp_state_t;
endpackage

/* File: hdl/bdsp_core.sv */
// background debug entry logic and 17-bit serial link
// Behaviour
// - with debug enabled, break request, entry instruction, double fault or peripheral enter debug
// - with debug disabled, break request takes breakpoint exception vector 0x0c
// - software breakpoint instruction never enters debug; it stays illegal
// - double bus fault halts when disabled, enters debug when enabled
// - opcode 0x4afa enters debug when enabled, else illegal instruction trap
// - no breakpoint acknowledge cycle on entry by break request
// - peripheral break requests share the external request line, treated alike
// - on entry suspend execution, raise halted output, enable serial, await command
// - cause register: double fault status/ffff, instruction 0/1, breakpoint 0/0
// - double fault right after reset sets instruction pointer to 0x00000001
// - commands are 16-bit words; results shift out with next command (here a result goes out with the second command after its own)
// - fault address holds faulting address until later bus cycle overwrites
// - resume fetches from return counter; odd value gives address error
// - resume or call ends debug, flushes pipeline, keeps counter and space bit
// - drop halted before prefetch, then disable serial, restore pipeline pins (here the pins return as halted drops, one cycle before prefetch)
// - in debug, break pin is serial clock, fetch pin in, pipe pin out
// - msb first, outputs change after falling edge, sample on rising
// - serial word is 17 bits: status bit 16 then 16 data bits
// - responses encode valid, complete, not ready, bus error, illegal
// - incoming bit 16 is ignored
// - debug enabled only when break request low at reset release, until next reset
module bdsp_core
  import bdsp_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        rst,
  // shared debug pins
  input  wire logic        break_request_n,
  input  wire logic        debug_serial_clock,
  input  wire logic        fetch_flag_in,
  input  wire logic        pipe_track_pipe_advance_out,
  input  wire logic        pipe_track_fetch_flag_out,
  output logic             pipe_advance_out,
  output logic             fetch_flag_out,
  output logic             fetch_flag_oe,
  // core event inputs
  input  wire logic        insn_valid,
  input  wire logic [15:0] insn_opcode,
  input  wire logic [31:0] insn_addr,
  input  wire logic        double_fault,
  input  wire logic [15:0] special_status_word,
  input  wire logic        first_fetch_after_reset,
  input  wire logic        bus_cycle_done,
  input  wire logic [31:0] bus_cycle_addr,
  input  wire logic        bus_error_input,
  // core control outputs
  output logic             debug_halt_mode,
  output logic             halted,
  output logic             exc_take,
  output logic [7:0]       exc_vector,
  output logic             brk_ack_cycle,
  output logic             pipe_flush,
  output logic             prefetch_start,
  output logic [31:0]      prefetch_addr,
  // command side toward microcode
  output logic             cmd_word_valid,
  output logic [15:0]      cmd_word,
  input  wire logic        rsp_load,
  input  wire logic        rsp_status,
  input  wire logic [15:0] rsp_data,
  input  wire logic        cmd_resume,
  input  wire logic [31:0] return_program_counter,
  input  wire logic        supervisor_space_bit,
  // debug registers
  output logic [31:0]      temp_cause_register,
  output logic [31:0]      current_instruction_pointer,
  output logic [31:0]      fault_address_register,
  output logic             supervisor_space_reg
);
  import bdsp_pkg::*;

  function automatic logic is_entry_insn(input logic [15:0] op);
    return op == OP_ENTRY_INSN;
  endfunction

  // pin synchronisers: no reset, they must follow the pin while reset is high
  // so that the strap below can see a low request before release
  logic brk_s1_reg, brk_s2_reg;
  always_ff @(posedge clk) begin
    brk_s1_reg <= break_request_n;
    brk_s2_reg <= brk_s1_reg;
  end

  // strap capture: low for two clocks before release enables debug
  logic [STRAP_CLKS-1:0] strap_low_reg;
  logic                  strap_done_reg;
  logic                  enabled_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_done_reg <= 1'b0;
      enabled_reg    <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      enabled_reg    <= &strap_low_reg;
    end
  end
  // history of synchronised low samples, runs through reset; an unknown
  // start value is flushed out after a few clocks
  always_ff @(posedge clk) begin
    strap_low_reg <= {strap_low_reg[STRAP_CLKS-2:0], !brk_s2_reg};
  end
  assign debug_halt_mode = enabled_reg;

  // entry decision
  bdsp_state_t state_reg;
  logic        frozen;
  logic        brk_req;
  logic        entry_insn;
  logic        enter;
  assign frozen     = (state_reg == BDSP_FROZEN);
  assign brk_req    = !brk_s2_reg && strap_done_reg && !frozen;
  assign entry_insn = insn_valid && is_entry_insn(insn_opcode);
  // software breakpoint opcodes simply fall through to illegal handling
  assign enter = (state_reg == BDSP_RUN) && enabled_reg &&
                 (brk_req || entry_insn || double_fault);

  logic resume_pulse;

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      state_reg <= BDSP_RUN;
    else begin
      case (state_reg)
        BDSP_RUN: begin
          if (enter)
            state_reg <= BDSP_FROZEN;
          else if (double_fault && !enabled_reg)
            state_reg <= BDSP_HALT;
        end
        BDSP_FROZEN: begin
          if (cmd_resume)
            state_reg <= BDSP_RUN;
        end
        BDSP_HALT:   state_reg <= BDSP_HALT;
        default:     state_reg <= BDSP_RUN;
      endcase
    end
  end
  assign halted = frozen || (state_reg == BDSP_HALT);
  assign resume_pulse = frozen && cmd_resume;

  // exceptions: break and entry instruction when debug is disabled, address error on odd prefetch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exc_take      <= 1'b0;
      exc_vector    <= 8'h00;
      brk_ack_cycle <= 1'b0;
    end else begin
      exc_take      <= 1'b0;
      brk_ack_cycle <= 1'b0;
      if (state_reg == BDSP_RUN && !enabled_reg) begin
        if (brk_req) begin
          exc_take      <= 1'b1;
          exc_vector    <= VEC_BREAKPOINT;
          brk_ack_cycle <= 1'b1;
        end else if (entry_insn) begin
          exc_take   <= 1'b1;
          exc_vector <= VEC_ILLEGAL;
        end
      end
      // entering debug never acknowledges on the bus
      // odd return counter faults when prefetch begins
      if (prefetch_start && prefetch_addr[0]) begin
        exc_take   <= 1'b1;
        exc_vector <= VEC_ADDR_ERR;
      end
    end
  end

  // cause and pointer capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      temp_cause_register         <= 32'h0;
      current_instruction_pointer <= 32'h0;
    end else if (enter) begin
      if (double_fault)
        temp_cause_register <= {special_status_word, CAUSE_DBF_LO};
      else if (entry_insn)
        temp_cause_register <= {CAUSE_ZERO_HI, CAUSE_INSN_LO};
      else
        temp_cause_register <= {CAUSE_ZERO_HI, CAUSE_HW_LO};
      if (double_fault && first_fetch_after_reset)
        current_instruction_pointer <= PCC_RESET_DBF;
      else
        current_instruction_pointer <= insn_addr;
    end
  end

  // fault address: last bus cycle address, frozen while in debug
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      fault_address_register <= 32'h0;
    else if (bus_cycle_done && !frozen)
      fault_address_register <= bus_cycle_addr;
  end

  // resume: flush then prefetch from return counter
  logic resume_d_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resume_d_reg         <= 1'b0;
      pipe_flush           <= 1'b0;
      prefetch_start       <= 1'b0;
      prefetch_addr        <= 32'h0;
      supervisor_space_reg <= 1'b1;
    end else begin
      resume_d_reg   <= resume_pulse;
      pipe_flush     <= resume_pulse;
      prefetch_start <= resume_d_reg;
      if (resume_pulse) begin
        prefetch_addr        <= return_program_counter;
        supervisor_space_reg <= supervisor_space_bit;
      end
    end
  end
  // link domain: shift register on the serial clock. it is held in reset
  // from one clock after the core leaves frozen until one clock after entry; the host clocks only while halted, so
  // release never meets a serial edge and no bit is lost to a synchroniser
  logic link_en_reg;
  logic link_rst;
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      link_en_reg <= 1'b0;
    else
      link_en_reg <= frozen;
  end
  assign link_rst = rst || !link_en_reg;

  logic [4:0]  bit_cnt_reg;
  logic [16:0] rx_reg;
  logic [16:0] tx_reg;
  logic [15:0] rx_word_reg;
  logic        rx_tgl_reg;
  logic        dso_reg;
  logic        ld_tgl_reg;
  logic [16:0] rsp_hold_reg;
  logic        ld_s1_reg, ld_s2_reg, ld_seen_reg;

  always_ff @(posedge debug_serial_clock or posedge link_rst) begin
    if (link_rst) begin
      ld_s1_reg <= 1'b0;
      ld_s2_reg <= 1'b0;
    end else begin
      ld_s1_reg <= ld_tgl_reg;
      ld_s2_reg <= ld_s1_reg;
    end
  end

  always_ff @(posedge debug_serial_clock or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_reg <= 5'd0;
      rx_reg      <= 17'h0;
      rx_word_reg <= 16'h0;
      rx_tgl_reg  <= 1'b0;
      tx_reg      <= {1'b1, RSP_NOT_READY};
      ld_seen_reg <= 1'b0;
    end else begin
      rx_reg <= {rx_reg[15:0], fetch_flag_in};
      if (bit_cnt_reg == 5'(WORD_BITS - 1)) begin
        bit_cnt_reg <= 5'd0;
        rx_word_reg <= {rx_reg[14:0], fetch_flag_in};
        rx_tgl_reg  <= ~rx_tgl_reg;
        if (ld_s2_reg != ld_seen_reg) begin
          tx_reg      <= rsp_hold_reg;
          ld_seen_reg <= ld_s2_reg;
        end else
          tx_reg <= {1'b1, RSP_NOT_READY};
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 5'd1;
        tx_reg      <= {tx_reg[15:0], 1'b0};
      end
    end
  end

  // output changes after the falling edge
  always_ff @(negedge debug_serial_clock or posedge link_rst) begin
    if (link_rst)
      dso_reg <= 1'b1;
    else
      dso_reg <= tx_reg[STAT_POS];
  end

  // core side: response hold and word receive toggle
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ld_tgl_reg   <= 1'b0;
      rsp_hold_reg <= {1'b1, RSP_NOT_READY};
      rx_s1_reg    <= 1'b0;
      rx_s2_reg    <= 1'b0;
      rx_s3_reg    <= 1'b0;
      cmd_word     <= 16'h0;
    end else begin
      rx_s1_reg <= rx_tgl_reg;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg != rx_s3_reg)
        cmd_word <= rx_word_reg;
      // link side restarts its toggle copy at zero on every entry
      if (!frozen)
        ld_tgl_reg <= 1'b0;
      else if (rsp_load) begin
        rsp_hold_reg <= {rsp_status, rsp_data};
        ld_tgl_reg   <= ~ld_tgl_reg;
      end
    end
  end
  assign cmd_word_valid = (rx_s2_reg != rx_s3_reg) && frozen;

  // pin muxing between tracking and serial use
  assign pipe_advance_out = frozen ? dso_reg : pipe_track_pipe_advance_out;
  assign fetch_flag_out   = pipe_track_fetch_flag_out;
  assign fetch_flag_oe    = !frozen;

  // checks
  a_halt_on_entry: assert property (@(posedge clk) disable iff (rst)
    enter |=> halted && frozen)
    else $error("halted not raised after entry");
  a_brk_vector: assert property (@(posedge clk) disable iff (rst)
    (state_reg == BDSP_RUN && !enabled_reg && brk_req) |=> exc_take && exc_vector == 8'h0c)
    else $error("breakpoint vector wrong");
  a_no_ack_entry: assert property (@(posedge clk) disable iff (rst)
    enter |=> !brk_ack_cycle)
    else $error("acknowledge cycle on entry");
  a_insn_cause: assert property (@(posedge clk) disable iff (rst)
    (enter && entry_insn && !double_fault) |=> temp_cause_register == 32'h00000001)
    else $error("entry instruction cause wrong");
  a_dbf_halt: assert property (@(posedge clk) disable iff (rst)
    (state_reg == BDSP_RUN && double_fault && !enabled_reg) |=> state_reg == BDSP_HALT)
    else $error("double fault did not halt");
  a_illegal_insn: assert property (@(posedge clk) disable iff (rst)
    (state_reg == BDSP_RUN && !enabled_reg && !brk_req && entry_insn)
      |=> exc_take && exc_vector == 8'h04)
    else $error("entry instruction not illegal");
  a_resume_order: assert property (@(posedge clk) disable iff (rst)
    resume_pulse |=> !halted ##1 prefetch_start)
    else $error("prefetch before halted negated");
  a_pin_release: assert property (@(posedge clk) disable iff (rst)
    frozen |-> !fetch_flag_oe && pipe_advance_out == dso_reg)
    else $error("pins not in serial use");
  a_dbf_pointer: assert property (@(posedge clk) disable iff (rst)
    (enter && double_fault && first_fetch_after_reset)
      |=> current_instruction_pointer == 32'h00000001)
    else $error("pointer not one after reset fault");
  a_word_len: assert property (@(posedge debug_serial_clock) disable iff (link_rst)
    bit_cnt_reg <= 5'd16)
    else $error("bit count past word");
  a_odd_fetch: assert property (@(posedge clk) disable iff (rst)
    (prefetch_start && prefetch_addr[0]) |=> exc_take && exc_vector == VEC_ADDR_ERR)
    else $error("odd return counter not faulted");
  a_hw_cause: assert property (@(posedge clk) disable iff (rst)
    (enter && !entry_insn && !double_fault) |=> temp_cause_register == 32'h00000000)
    else $error("breakpoint cause wrong");
  a_dbf_cause: assert property (@(posedge clk) disable iff (rst)
    (enter && double_fault) |=> temp_cause_register[15:0] == 16'hffff)
    else $error("double fault cause wrong");
  a_flush_resume: assert property (@(posedge clk) disable iff (rst)
    resume_pulse |=> pipe_flush && prefetch_addr == $past(return_program_counter))
    else $error("resume did not flush");
  a_fault_addr: assert property (@(posedge clk) disable iff (rst)
    (bus_cycle_done && !frozen) |=> fault_address_register == $past(bus_cycle_addr))
    else $error("fault address not captured");
  a_link_free: assert property (@(posedge clk) disable iff (rst)
    !frozen |-> fetch_flag_oe && pipe_advance_out == pipe_track_pipe_advance_out)
    else $error("pins not returned to tracking");
  a_break_entry: assert property (@(posedge clk) disable iff (rst)
    (state_reg == BDSP_RUN && enabled_reg && brk_req) |=> halted)
    else $error("break request did not enter debug");
endmodule

/* File: bench/bdsp_host.sv */
// host model: clock master of the debug serial link
module bdsp_host (
  // serial link
  output logic      sclk,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk = 1'b1;
    sdi  = 1'b1;
  end
  // 80 ns period keeps well under half the system clock
  task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
    for (int i = 16; i >= 0; i--) begin // 17 bits, msb first
      sclk = 1'b0;
      #2 sdi = tx[i];
      #38 sclk = 1'b1;
      rx[i] = sdo;
      #40;
    end
    sdi = ~sdi; // clock stands high, data line shows no stale bit
  endtask
endmodule

/* File: bench/tb_background_debug_serial_port.sv */
// self-checking bench for debug entry, serial link and resume
module tb_background_debug_serial_port;
  timeunit 1ns;
  timeprecision 100ps;
  import bdsp_pkg::*;
  localparam logic [15:0] RD_SYS_CMD = 16'h0000; // arbitrary command code
  logic clk = 1'b0, rst = 1'b1, break_request_n = 1'b0, insn_valid = 1'b0;
  logic double_fault = 1'b0, first_fetch_after_reset = 1'b0, bus_cycle_done = 1'b0;
  logic rsp_load = 1'b0, rsp_status = 1'b0, cmd_resume = 1'b0, supervisor_space_bit = 1'b0;
  logic pipe_track_pipe_advance_out = 1'b0, pipe_track_fetch_flag_out = 1'b0;
  logic [15:0] insn_opcode = 16'h0000, special_status_word = 16'h0000, rsp_data = 16'h0000;
  logic [31:0] insn_addr = 32'h0, bus_cycle_addr = 32'h0, return_program_counter = 32'h0;
  logic debug_serial_clock, fetch_flag_in, pipe_advance_out, fetch_flag_out, fetch_flag_oe;
  logic debug_halt_mode, halted, exc_take, brk_ack_cycle, pipe_flush, prefetch_start;
  logic cmd_word_valid, supervisor_space_reg;
  logic [7:0]  exc_vector;
  logic [15:0] cmd_word;
  logic [31:0] prefetch_addr, temp_cause_register, current_instruction_pointer;
  logic [31:0] fault_address_register, r32;
  logic [16:0] rx;
  logic [16:0] tbl[5];
  logic [15:0] exp_q[$];
  int error_cnt = 0, total_checks = 0, ack_cnt = 0;

  bdsp_core i_dut (
    .clk, .rst, .break_request_n, .debug_serial_clock, .fetch_flag_in, .pipe_track_pipe_advance_out,
    .pipe_track_fetch_flag_out, .pipe_advance_out, .fetch_flag_out, .fetch_flag_oe, .insn_valid,
    .insn_opcode, .insn_addr, .double_fault, .special_status_word, .first_fetch_after_reset,
    .bus_cycle_done, .bus_cycle_addr, .bus_error_input(1'b0), .debug_halt_mode, .halted,
    .exc_take, .exc_vector, .brk_ack_cycle, .pipe_flush, .prefetch_start, .prefetch_addr,
    .cmd_word_valid, .cmd_word, .rsp_load, .rsp_status, .rsp_data, .cmd_resume,
    .return_program_counter, .supervisor_space_bit, .temp_cause_register,
    .current_instruction_pointer, .fault_address_register, .supervisor_space_reg
  );
  bdsp_host i_host (.sclk(debug_serial_clock), .sdi(fetch_flag_in), .sdo(pipe_advance_out));

  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (brk_ack_cycle === 1'b1) ack_cnt++;
  end
  // command watcher: oldest noted command against the assembled word
  always @(posedge clk) begin
    if (cmd_word_valid === 1'b1) begin
      @(posedge clk);
      #1 chk(cmd_word, exp_q.pop_front());
    end
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic reset_dut(input logic strap);
    rst = 1'b1;
    break_request_n = strap;
    step(5);
    rst = 1'b0;
  endtask
  task automatic run_insn(input logic [15:0] op);
    insn_opcode = op;
    insn_addr = $urandom & 32'hffff_fffe;
    insn_valid = 1'b1;
    step(1);
    insn_valid = 1'b0;
  endtask
  task automatic word(input logic [15:0] cmd, input logic b16, input logic [16:0] exp);
    exp_q.push_back(cmd);
    i_host.xfer({b16, cmd}, rx);
    chk(rx, exp);
    step(1);
  endtask
  task automatic load_rsp(input logic [16:0] w);
    {rsp_status, rsp_data} = w;
    rsp_load = 1'b1;
    step(1);
    rsp_load = 1'b0;
  endtask
  task automatic resume(input logic odd);
    return_program_counter = ($urandom & 32'hffff_fffe) | 32'(odd); // odd: address error
    supervisor_space_bit = 1'($urandom);
    {pipe_track_pipe_advance_out, pipe_track_fetch_flag_out} = 2'($urandom);
    cmd_resume = 1'b1;
    step(1);
    cmd_resume = 1'b0;
    chk({halted, pipe_flush}, 2'b01);
    step(1);
    chk({prefetch_start, prefetch_addr}, {1'b1, return_program_counter});
    chk(supervisor_space_reg, supervisor_space_bit);
    chk({pipe_advance_out, fetch_flag_out, fetch_flag_oe},
        {pipe_track_pipe_advance_out, pipe_track_fetch_flag_out, 1'b1});
    step(1);
    chk({exc_take, exc_take ? exc_vector : 8'h00},
        {odd, odd ? VEC_ADDR_ERR : 8'h00});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #50us;
    error_cnt++;
    complete_run();
  end
  initial begin
    r32 = $urandom(32'hc87789b5);
    // break held low through and after reset: strap, then breakpoint entry
    reset_dut(1'b0);
    step(6);
    chk(debug_halt_mode, 1'b1);
    chk(halted, 1'b1);
    chk(temp_cause_register, {CAUSE_ZERO_HI, CAUSE_HW_LO});
    chk({ack_cnt[7:0], exc_take, fetch_flag_oe}, 10'h0);
    break_request_n = 1'b1;
    tbl = '{{1'b0, 16'($urandom)}, {1'b0, RSP_COMPLETE}, {1'b1, RSP_NOT_READY},
            {1'b1, RSP_BUS_ERR}, {1'b1, RSP_ILLEGAL}};
    // first command is RD_SYS_CMD; the response loaded after it is a random data word
    for (int i = 0; i < 7; i++) begin
      word(i == 0 ? RD_SYS_CMD : 16'($urandom), i == 3,
           i < 2 ? {1'b1, RSP_NOT_READY} : tbl[(i + 3) % 5]);
      if (i < 5) load_rsp(tbl[i]);
    end
    step(8);
    resume(1'b0);
    $display("test breakpoint entry and link done");
    bus_cycle_addr = $urandom;
    bus_cycle_done = 1'b1;
    step(1);
    bus_cycle_done = 1'b0;
    r32 = bus_cycle_addr;
    bus_cycle_addr = ~r32;
    step(3);
    chk(fault_address_register, r32);
    run_insn(16'h4848);
    step(1);
    chk(halted, 1'b0);
    run_insn(OP_ENTRY_INSN);
    chk({halted, temp_cause_register}, {1'b1, CAUSE_ZERO_HI, CAUSE_INSN_LO});
    resume(1'b0);
    special_status_word = 16'($urandom);
    first_fetch_after_reset = 1'b1;
    double_fault = 1'b1;
    step(1);
    double_fault = 1'b0;
    chk({halted, temp_cause_register}, {1'b1, special_status_word, CAUSE_DBF_LO});
    chk(current_instruction_pointer, PCC_RESET_DBF);
    first_fetch_after_reset = 1'b0;
    resume(1'b1);
    $display("test entry sources done");
    // strap high: debug disabled until next reset
    reset_dut(1'b1);
    step(3);
    chk(debug_halt_mode, 1'b0);
    break_request_n = 1'b0;
    for (int k = 0; k < 10 && exc_take !== 1'b1; k++) step(1);
    break_request_n = 1'b1;
    chk({exc_take, exc_vector, brk_ack_cycle}, {1'b1, VEC_BREAKPOINT, 1'b1});
    step(6);
    run_insn(OP_ENTRY_INSN);
    chk({exc_take, exc_vector, halted}, {1'b1, VEC_ILLEGAL, 1'b0});
    step(2);
    double_fault = 1'b1;
    step(1);
    double_fault = 1'b0;
    step(20);
    chk({halted, debug_halt_mode}, 2'b10);
    $display("test debug disabled done");
    complete_run();
  end
endmodule
